// [shared/iprc_pkg.sv]
// package for the interrupt priority configuration slice
// assumes a 16-bit register port with one-cycle read latency
package iprc_pkg;
   // ==========================================================
   // register map
   localparam logic [3:0] TMR_REG_ADDR = 4'h0;
   localparam logic [3:0] EXT_REG_ADDR = 4'h1;
   // ==========================================================
   // field positions
   localparam int EXT1_LSB = 0;
   localparam int CH3_LSB = 4;
   localparam int CH4_LSB = 8;
   localparam int TMR4_LSB = 12;
   localparam int PRIO_W = 3;
   // ==========================================================
   // reset value, off level and source count
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam int NUM_SRC = 4;
   // ==========================================================
   // per-source priority output and register bus bundle
   typedef struct packed {
      logic [2:0] level;
      logic enabled;
   } iprc_prio_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } iprc_bus_t;
endpackage : iprc_pkg

// [rtl/iprc_field.sv]
// one 3-bit priority field with enable decode
// assumes the caller decodes the register address
`timescale 1ns/1ps
`default_nettype none
module iprc_field (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_we,
   input wire logic [2:0] i_wdata,
   output logic [2:0] o_level,
   output iprc_pkg::iprc_prio_t o_prio
);
   // ==========================================================
   // storage
   // reset to level 4
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_level <= iprc_pkg::PRIO_RESET;
      end else if (i_we) begin
         o_level <= i_wdata;
      end
   end
   // ==========================================================
   // decoded view, registered so the top drives flops
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prio <= '{level: iprc_pkg::PRIO_RESET, enabled: 1'b1};
      end else begin
         o_prio.level <= o_level;
         o_prio.enabled <= (o_level != iprc_pkg::PRIO_OFF);
      end
   end
endmodule : iprc_field
`default_nettype wire

// [rtl/iprc_regs.sv]
// priority configuration registers: timer4/compare and external int 1
// assumes a simple synchronous register port, master never waits
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module iprc_regs (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   output iprc_pkg::iprc_prio_t [3:0] o_prio,
   output logic [1:0] o_max_src
);
   // ==========================================================
   // field table: 0 ext1, 1 ch3, 2 ch4, 3 timer4
   localparam int LSB [4] = '{iprc_pkg::EXT1_LSB, iprc_pkg::CH3_LSB,
                              iprc_pkg::CH4_LSB, iprc_pkg::TMR4_LSB};
   // owning register of each field, same order as the table above
   localparam logic [3:0] REG_OF [4] = '{iprc_pkg::EXT_REG_ADDR, iprc_pkg::TMR_REG_ADDR,
                                        iprc_pkg::TMR_REG_ADDR, iprc_pkg::TMR_REG_ADDR};
   logic [2:0] level [4];
   logic [3:0] we;
   logic hit_ext;
   logic hit_tmr;

   // ==========================================================
   // elaboration checks
   // port widths are fixed at four fields of three bits each
   if (iprc_pkg::NUM_SRC != 4) begin : g_bad_num
      $error("iprc_regs needs exactly four priority fields");
   end
   if (iprc_pkg::PRIO_W != 3) begin : g_bad_width
      $error("iprc_regs needs three-bit priority fields");
   end
   // one shared index would alias every field
   if (iprc_pkg::EXT_REG_ADDR == iprc_pkg::TMR_REG_ADDR) begin : g_bad_addr
      $error("register indices must differ");
   end
   // fields of the shared register must not overlap
   if ((iprc_pkg::CH4_LSB < iprc_pkg::CH3_LSB + iprc_pkg::PRIO_W) ||
       (iprc_pkg::TMR4_LSB < iprc_pkg::CH4_LSB + iprc_pkg::PRIO_W)) begin : g_bad_overlap
      $error("priority fields overlap");
   end
   for (genvar k = 0; k < 4; k++) begin : g_chk_fld
      if (LSB[k] + iprc_pkg::PRIO_W > 16) begin : g_bad_pos
         $error("priority field runs past bit 15");
      end
   end

   // ==========================================================
   // address decode
   // any other index hits neither register: writes drop, reads give zero
   assign hit_ext = (i_addr == iprc_pkg::EXT_REG_ADDR);
   assign hit_tmr = (i_addr == iprc_pkg::TMR_REG_ADDR);

   genvar g;
   generate
      for (g = 0; g < iprc_pkg::NUM_SRC; g++) begin : g_fld
         // written only through its own register
         assign we[g] = i_wr && (i_addr == REG_OF[g]);
         iprc_field u_fld (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(i_rst_n),
            .i_we(we[g]),
            .i_wdata(i_wdata[LSB[g] +: iprc_pkg::PRIO_W]),
            .o_level(level[g]),
            .o_prio(o_prio[g])
         );
      end
   endgenerate

   // ==========================================================
   // read port, one cycle latency
   logic [15:0] img_ext;
   logic [15:0] img_tmr;
   logic [15:0] rd_d;
   // bits outside the fields stay zero
   always_comb begin
      img_ext = 16'h0000;
      img_tmr = 16'h0000;
      for (int i = 0; i < iprc_pkg::NUM_SRC; i++) begin
         if (REG_OF[i] == iprc_pkg::EXT_REG_ADDR) begin
            img_ext[LSB[i] +: iprc_pkg::PRIO_W] = level[i];
         end else begin
            img_tmr[LSB[i] +: iprc_pkg::PRIO_W] = level[i];
         end
      end
   end

   // unmapped index reads zero
   always_comb begin
      rd_d = 16'h0000;
      if (hit_ext) begin
         rd_d = img_ext;
      end else if (hit_tmr) begin
         rd_d = img_tmr;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= rd_d;
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // ==========================================================
   // highest enabled source, lowest index wins ties
   logic [1:0] best_d;
   logic [2:0] best_lvl;
   always_comb begin
      best_d = 2'h0;
      best_lvl = 3'h0;
      for (int i = 0; i < iprc_pkg::NUM_SRC; i++) begin
         // a zero field never beats the start value
         if (level[i] > best_lvl) begin
            best_lvl = level[i];
            best_d = 2'(i);
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_max_src <= 2'h0;
      end else begin
         o_max_src <= best_d;
      end
   end
endmodule : iprc_regs
`default_nettype wire

// [sim/iprc_regs_assertions.sv]
// checker for the priority registers
// assumes binding onto iprc_regs
`timescale 1ns/1ps
`default_nettype none
module iprc_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire iprc_pkg::iprc_prio_t [3:0] o_prio,
   input wire logic [1:0] o_max_src
);
   // ====================
   // properties
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_wr1; i_wr && i_addr == 4'h1; endsequence
   property p_rb; s_wr1 ##1 i_rd && i_addr == 4'h1 |=> o_rdata[2:0] == $past(i_wdata[2:0], 2); endproperty
   property p_top; s_wr1 ##0 i_wdata[2:0] == 3'h7 |-> ##2 o_prio[0].level == 3'h7; endproperty
   property p_lvl; s_wr1 |-> ##2 o_prio[0].level == $past(i_wdata[2:0], 2); endproperty
   property p_off; o_prio[0].enabled == |o_prio[0].level && o_prio[3].enabled == |o_prio[3].level; endproperty
   property p_hi; i_rd && i_addr == 4'h1 |=> o_rdata[15:3] == 13'h0000; endproperty
   property p_rst; $rose(i_rst_n) |-> o_prio[3].level == 3'h4; endproperty
   property p_gap; i_rd && i_addr == 4'h0 |=> (o_rdata & 16'h888F) == 16'h0000; endproperty
   // reported source must hold a level no lower than any other
   property p_max;
      o_prio[o_max_src].level >= o_prio[0].level && o_prio[o_max_src].level >= o_prio[1].level &&
      o_prio[o_max_src].level >= o_prio[2].level && o_prio[o_max_src].level >= o_prio[3].level;
   endproperty
   a_rb: assert property (p_rb) else $error("readback");
   a_top: assert property (p_top) else $error("top level");
   a_lvl: assert property (p_lvl) else $error("level");
   a_off: assert property (p_off) else $error("enable");
   a_hi: assert property (p_hi) else $error("high bits");
   a_rst: assert property (p_rst) else $error("reset");
   a_gap: assert property (p_gap) else $error("gap bits");
   a_max: assert property (p_max) else $error("highest source");
endmodule : iprc_chk
bind iprc_regs iprc_chk u_chk (.*);
`default_nettype wire

// [sim/iprc_regs_tb.sv]
// bench for the priority registers
// assumes iprc_regs and its checker
`timescale 1ns/1ps
`default_nettype none
module iprc_regs_tb;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [15:0] o_rdata;
   iprc_pkg::iprc_prio_t [3:0] o_prio;
   logic [1:0] o_max_src;
   int fails = 0;
   int checked = 0;
   // ====================
   // clock, design, tasks
   always #5 i_sys_clk = ~i_sys_clk;
   iprc_regs DUT (.*);
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // never call twice in a row: strobe would be set twice
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, e);
      @(posedge i_sys_clk);
   endtask : rd
   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // ====================
   // tests
   initial begin
      logic [2:0] c;
      repeat (8) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      rd(4'h0, 16'h4440);
      rd(4'h1, 16'h0004);
      $display("reset test end");
      wr(4'h1, 16'hFFFF);
      rd(4'h1, 16'h0007);
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wr(4'h1, {13'h0000, c});
         rd(4'h1, {13'h0000, c});
         @(negedge i_sys_clk);
         chk({12'h000, o_prio[0]}, {12'h000, c, |c});
         @(posedge i_sys_clk);
      end
      $display("code test end");
      wr(4'h0, 16'hFFFF);
      rd(4'h0, 16'h7770);
      @(negedge i_sys_clk);
      chk({12'h000, o_prio[3]}, 16'h000F);
      chk({14'h0000, o_max_src}, 16'h0000);
      @(posedge i_sys_clk);
      wr(4'h2, 16'h0000);
      rd(4'h2, 16'h0000);
      rd(4'h0, 16'h7770);
      $display("mask test end");
      wr(4'h1, 16'h0000);
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'h1230);
      rd(4'h0, 16'h1230);
      @(negedge i_sys_clk);
      chk({12'h000, o_prio[0]}, 16'h0000);
      chk({12'h000, o_prio[1]}, 16'h0007);
      chk({12'h000, o_prio[2]}, 16'h0005);
      chk({12'h000, o_prio[3]}, 16'h0003);
      chk({14'h0000, o_max_src}, 16'h0001);
      @(posedge i_sys_clk);
      wr(4'h0, 16'h7120);
      rd(4'h0, 16'h7120);
      @(negedge i_sys_clk);
      chk({12'h000, o_prio[3]}, 16'h000F);
      chk({14'h0000, o_max_src}, 16'h0003);
      @(posedge i_sys_clk);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0000);
      @(negedge i_sys_clk);
      chk({12'h000, o_prio[1]}, 16'h0000);
      chk({12'h000, o_prio[3]}, 16'h0000);
      chk({14'h0000, o_max_src}, 16'h0000);
      @(posedge i_sys_clk);
      $display("field test end");
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      rd(4'h0, 16'h4440);
      rd(4'h1, 16'h0004);
      $display("second reset test end");
      conclude();
   end
   initial begin
      #20000;
      fails++;
      conclude();
   end
endmodule : iprc_regs_tb
`default_nettype wire
